// file: hdl/cfr_regs.sv
`timescale 1ns/1ps
module cfr_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic singleEndedOut,
  output logic firstOutputSilence,
  output logic secondOutputSilence,
  output logic [1:0] outputDriverEnables,
  output logic [1:0] converterInputSelect,
  output logic [5:0] adcGain,
  output logic [5:0] dacGain
);
  // ==========================================================================
  // Bus decode
  logic access, wrEn, rdEn, hitSub, hitOutin, hitStat;
  logic [7:0] outin_reg;
  logic [5:0] adcGain_reg, dacGain_reg, side_reg;
  logic [1:0] readPtr_reg;
  logic [7:0] rdByte;
  logic [1:0] wrSel;

  assign access = psel && penable && !pready;
  assign hitSub = paddr == cfr_pkg::ADDR_SUBREG;
  assign hitOutin = paddr == cfr_pkg::ADDR_OUTIN;
  assign hitStat = paddr == cfr_pkg::ADDR_STATUS;
  assign wrEn = access && pwrite;
  assign rdEn = access && !pwrite;
  assign wrSel = pwdata[cfr_pkg::SEL_HI:cfr_pkg::SEL_LO];

  // One wait state: answer comes one edge after the access phase starts
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access && !(hitSub || hitOutin || hitStat);
    end
  end

  // ==========================================================================
  // Output/input control; reserved bit is masked so it never stores
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      outin_reg <= cfr_pkg::OUTIN_RESET;
    end else if (wrEn && hitOutin) begin
      outin_reg <= pwdata[7:0] & cfr_pkg::OUTIN_RW_MASK;
    end
  end

  // Sub-register writes; version code falls through untouched
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      adcGain_reg <= cfr_pkg::GAIN_RESET;
      dacGain_reg <= cfr_pkg::GAIN_RESET;
      side_reg <= cfr_pkg::SIDETONE_RESET;
    end else if (wrEn && hitSub) begin
      case (wrSel)
        cfr_pkg::SEL_ADC_GAIN: adcGain_reg <= pwdata[5:0];
        cfr_pkg::SEL_DAC_GAIN: dacGain_reg <= pwdata[5:0];
        cfr_pkg::SEL_SIDETONE:
          side_reg <= pwdata[5:0] & cfr_pkg::SIDETONE_RW_MASK;
        default: ; // Version is read-only
      endcase
    end
  end

  // Read sequence pointer: each sub-register read advances, wraps at four
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readPtr_reg <= cfr_pkg::SEL_ADC_GAIN;
    end else if (rdEn && hitSub) begin
      readPtr_reg <= readPtr_reg + 2'h1;
    end
  end

  // Read mux: on sub-register reads the selector code rides in the top two bits of the byte
  always_comb begin
    rdByte = 8'h00;
    if (hitOutin) begin
      rdByte = outin_reg; // Bit 0 held at zero
    end else if (hitStat) begin
      rdByte = {6'h00, readPtr_reg};
    end else if (hitSub) begin
      case (readPtr_reg)
        cfr_pkg::SEL_ADC_GAIN: rdByte = {readPtr_reg, adcGain_reg};
        cfr_pkg::SEL_DAC_GAIN: rdByte = {readPtr_reg, dacGain_reg};
        cfr_pkg::SEL_SIDETONE: rdByte = {readPtr_reg, side_reg};
        default: rdByte = {readPtr_reg, cfr_pkg::CHIP_VERSION_ID};
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      prdata <= {24'h000000, rdByte};
    end
  end

  // ==========================================================================
  // Control outputs registered from the field store; the extra stage keeps
  // every pin glitch free at the price of one cycle of delay
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      singleEndedOut <= 1'b0;
      firstOutputSilence <= 1'b0;
      secondOutputSilence <= 1'b0;
      outputDriverEnables <= 2'h0;
      converterInputSelect <= cfr_pkg::IN_PAIR1;
    end else begin
      singleEndedOut <= outin_reg[cfr_pkg::CFG_BIT];
      firstOutputSilence <= outin_reg[cfr_pkg::SILENCE1_BIT];
      secondOutputSilence <= outin_reg[cfr_pkg::SILENCE2_BIT];
      outputDriverEnables <=
        outin_reg[cfr_pkg::DRV_HI:cfr_pkg::DRV_LO];
      converterInputSelect <=
        outin_reg[cfr_pkg::INSEL_HI:cfr_pkg::INSEL_LO];
    end
  end

  // Gain copies for the analog side; both start at their reset code
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      adcGain <= cfr_pkg::GAIN_RESET;
      dacGain <= cfr_pkg::GAIN_RESET;
    end else begin
      adcGain <= adcGain_reg;
      dacGain <= dacGain_reg;
    end
  end

  // ==========================================================================
  // Assertions
  // Pin checks look two edges past the write: the field store and the pin
  // register each add one stage
  // An accepted read of the sub-register window
  sequence subRead;
    rdEn && hitSub;
  endsequence

  // The accepted read that lands on the version slot
  sequence versionRead;
    rdEn && hitSub && readPtr_reg == cfr_pkg::SEL_VERSION;
  endsequence

  // A write aimed at the read-only version slot
  sequence versionWrite;
    wrEn && hitSub && wrSel == cfr_pkg::SEL_VERSION;
  endsequence

  // An accepted write of the output/input control register
  sequence fieldWrite;
    wrEn && hitOutin;
  endsequence

  // An access to an address that no register answers
  sequence strayAccess;
    access && !(hitSub || hitOutin || hitStat);
  endsequence

  a_version_read: assert property (@(posedge clk)
    disable iff (!reset_n)
    versionRead |=>
    prdata[7:0] == {cfr_pkg::SEL_VERSION, cfr_pkg::CHIP_VERSION_ID})
    else $error("version read wrong");
  a_version_kept: assert property (@(posedge clk)
    disable iff (!reset_n)
    versionWrite |=> $stable(adcGain_reg) && $stable(dacGain_reg) &&
    $stable(side_reg))
    else $error("version write changed a sub-register");
  a_read_order: assert property (@(posedge clk)
    disable iff (!reset_n)
    subRead |=> readPtr_reg == $past(readPtr_reg) + 2'h1)
    else $error("read order not advancing");
  a_read_wrap: assert property (@(posedge clk)
    disable iff (!reset_n)
    versionRead |=> readPtr_reg == cfr_pkg::SEL_ADC_GAIN)
    else $error("read order does not wrap");
  a_ptr_on_write: assert property (@(posedge clk)
    disable iff (!reset_n)
    (wrEn && hitSub) |=> $stable(readPtr_reg))
    else $error("write moved the read pointer");
  a_config_follow: assert property (@(posedge clk)
    disable iff (!reset_n)
    fieldWrite |=> ##1
    singleEndedOut == $past(pwdata[cfr_pkg::CFG_BIT], 2))
    else $error("config bit not applied");
  a_mute_one: assert property (@(posedge clk)
    disable iff (!reset_n)
    fieldWrite |=> ##1
    firstOutputSilence == $past(pwdata[cfr_pkg::SILENCE1_BIT], 2))
    else $error("first mute wrong");
  a_mute_two: assert property (@(posedge clk)
    disable iff (!reset_n)
    fieldWrite |=> ##1
    secondOutputSilence == $past(pwdata[cfr_pkg::SILENCE2_BIT], 2))
    else $error("second mute wrong");
  a_driver_en: assert property (@(posedge clk)
    disable iff (!reset_n)
    fieldWrite |=> ##1
    outputDriverEnables == $past(pwdata[cfr_pkg::DRV_HI:cfr_pkg::DRV_LO], 2))
    else $error("driver enables wrong");
  a_input_sel: assert property (@(posedge clk)
    disable iff (!reset_n)
    fieldWrite |=> ##1
    converterInputSelect ==
    $past(pwdata[cfr_pkg::INSEL_HI:cfr_pkg::INSEL_LO], 2))
    else $error("input select wrong");
  a_reserved_zero: assert property (@(posedge clk)
    disable iff (!reset_n)
    (rdEn && hitOutin) |=> prdata[0] == 1'b0 && pready)
    else $error("reserved bit reads one");
  a_reserved_store: assert property (@(posedge clk)
    disable iff (!reset_n)
    fieldWrite |=> (outin_reg & ~cfr_pkg::OUTIN_RW_MASK) == 8'h00)
    else $error("reserved bit stored");
  a_reset_fields: assert property (@(posedge clk)
    !reset_n |=> !singleEndedOut && !firstOutputSilence &&
    !secondOutputSilence && outputDriverEnables == 2'h0 &&
    converterInputSelect == cfr_pkg::IN_PAIR1)
    else $error("fields not cleared by reset");
  a_ready_pulse: assert property (@(posedge clk)
    disable iff (!reset_n)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_stray_refused: assert property (@(posedge clk)
    disable iff (!reset_n)
    strayAccess |=> pready && pslverr && $stable(outin_reg))
    else $error("unmapped access not refused");
endmodule

// file: inc/cfr_pkg.sv
package cfr_pkg;
  // ==========================================================================
  // Register map (APB byte addresses)
  localparam logic [7:0] ADDR_SUBREG = 8'h14;
  localparam logic [7:0] ADDR_OUTIN = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  // ==========================================================================
  // Sub-register selector codes in bits 7:6
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam logic [1:0] SEL_ADC_GAIN = 2'h0;
  localparam logic [1:0] SEL_DAC_GAIN = 2'h1;
  localparam logic [1:0] SEL_SIDETONE = 2'h2;
  localparam logic [1:0] SEL_VERSION = 2'h3;
  localparam logic [5:0] GAIN_RESET = 6'h2A;
  localparam logic [5:0] SIDETONE_RESET = 6'h38;
  localparam logic [5:0] SIDETONE_RW_MASK = 6'h3B;
  // Arbitrary neutral version value
  localparam logic [5:0] CHIP_VERSION_ID = 6'h05;
  // ==========================================================================
  // Output/input control fields
  localparam int CFG_BIT = 7;
  localparam int SILENCE1_BIT = 6;
  localparam int SILENCE2_BIT = 5;
  localparam int DRV_HI = 4;
  localparam int DRV_LO = 3;
  localparam int INSEL_HI = 2;
  localparam int INSEL_LO = 1;
  localparam logic [7:0] OUTIN_RESET = 8'h00;
  localparam logic [7:0] OUTIN_RW_MASK = 8'hFE;
  // Input source encodings
  localparam logic [1:0] IN_PAIR1 = 2'h0;
  localparam logic [1:0] IN_MIC_SELF = 2'h1;
  localparam logic [1:0] IN_MIC_EXT = 2'h2;
  localparam logic [1:0] IN_PAIR2 = 2'h3;
endpackage

// file: bench/codec_output_input_config_regs_tb.sv
`timescale 1ns/1ps
module codec_output_input_config_regs_tb;
  logic clk, resetN, psel, penable, pwrite, pready, pslverr, er;
  logic seOut, sil1, sil2;
  logic [7:0] fieldPins;
  logic [1:0] drvEn, inSel;
  logic [5:0] adcG, dacG;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  int num_errors = 0, tests_run = 0, seed = 32'h85CFDCDF, ptr, outin;
  int sub[4];
  cfr_regs i_dut (.clk(clk), .reset_n(resetN), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .singleEndedOut(seOut), .firstOutputSilence(sil1),
    .secondOutputSilence(sil2), .outputDriverEnables(drvEn),
    .converterInputSelect(inSel), .adcGain(adcG), .dacGain(dacG));
  // Field pins packed in register bit order, reserved bit as zero
  assign fieldPins = {seOut, sil1, sil2, drvEn, inSel, 1'b0};
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen, bounded against a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) chk(32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Clock and watchdog; the run needs well under 2000 cycles
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (4000) @(posedge clk);
    num_errors++;
    tally_and_finish;
  end
  // ==========================================================================
  // Main sequence
  initial begin
    resetN = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sub[0] = cfr_pkg::GAIN_RESET;
    sub[1] = cfr_pkg::GAIN_RESET;
    sub[2] = cfr_pkg::SIDETONE_RESET;
    sub[3] = cfr_pkg::CHIP_VERSION_ID;
    ptr = 0;
    outin = 0;
    repeat (5) @(posedge clk);
    resetN <= 1'b1;
    #1 chk(fieldPins, 0);
    apb(1'b0, cfr_pkg::ADDR_OUTIN, 32'h0);
    chk(rd, 0);
    $display("Reset test done");
    // Every input code, random other fields, reserved bit written random
    for (int i = 0; i < 8; i++) begin
      v = ($random(seed) & 32'hF9) | ((i % 4) << 1);
      apb(1'b1, cfr_pkg::ADDR_OUTIN, v);
      outin = v & 32'hFE;
      @(posedge clk);
      #1 chk(fieldPins, outin);
      apb(1'b0, cfr_pkg::ADDR_OUTIN, 32'h0);
      chk(rd, outin);
    end
    $display("Control field test done");
    // Sub-register writes, version write must be ignored
    for (int i = 0; i < 4; i++) begin
      v = ($random(seed) & 32'h3F) | (i << 6);
      apb(1'b1, cfr_pkg::ADDR_SUBREG, v);
      if (i < 3) sub[i] = v & (i == 2 ? 32'h3B : 32'h3F);
    end
    @(posedge clk);
    #1 chk({adcG, dacG}, (sub[0] << 6) | sub[1]);
    // Six reads show the order and the wrap back to the first gain
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, cfr_pkg::ADDR_SUBREG, 32'h0);
      chk(rd, (ptr << 6) | sub[ptr]);
      ptr = (ptr + 1) % 4;
    end
    apb(1'b0, cfr_pkg::ADDR_STATUS, 32'h0);
    chk(rd, ptr);
    $display("Sub-register test done");
    // Unmapped place refuses and leaves the control register alone
    apb(1'b1, 8'h20, 32'hFF);
    chk(er, 1);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1);
    chk(rd, 0);
    apb(1'b0, cfr_pkg::ADDR_OUTIN, 32'h0);
    chk(rd, outin);
    $display("Unmapped test done");
    // Mid-run reset must clear the fields and restart the read order
    resetN <= 1'b0;
    repeat (2) @(posedge clk);
    resetN <= 1'b1;
    #1 chk(fieldPins, 0);
    chk({adcG, dacG}, {cfr_pkg::GAIN_RESET, cfr_pkg::GAIN_RESET});
    apb(1'b0, cfr_pkg::ADDR_SUBREG, 32'h0);
    chk(rd, cfr_pkg::GAIN_RESET);
    $display("Mid-run reset test done");
    tally_and_finish;
  end
endmodule
